// ==== logic/gbcd_pkg.sv ====
package gbcd_pkg;

    // ========================================================
    // Address groups (seven command bits, parity ignored)
    // ========================================================
    localparam logic [6:0] LISTEN_BASE = 7'h20;
    localparam logic [6:0] TALK_BASE = 7'h40;
    localparam logic [6:0] UNLISTEN = 7'h3F;
    localparam logic [6:0] UNTALK = 7'h5F;
    localparam logic [1:0] GROUP_LISTEN = 2'h1;
    localparam logic [1:0] GROUP_TALK = 2'h2;
    localparam logic [1:0] GROUP_SECONDARY = 2'h3;
    localparam int GROUP_MSB = 6;
    localparam int GROUP_LSB = 5;

    // ========================================================
    // Multiline command codes
    // ========================================================
    localparam logic [6:0] CMD_GO_LOCAL = 7'h01;
    localparam logic [6:0] CMD_SEL_CLEAR = 7'h04;
    localparam logic [6:0] CMD_TRIGGER = 7'h08;
    localparam logic [6:0] CMD_LOCKOUT = 7'h11;
    localparam logic [6:0] CMD_DEV_CLEAR = 7'h14;
    localparam logic [6:0] CMD_POLL_ON = 7'h18;
    localparam logic [6:0] CMD_POLL_OFF = 7'h19;

    // ========================================================
    // Reset values
    // ========================================================
    localparam logic RESET_RELEASED = 1'b1;
    localparam logic RESET_FLAG = 1'b0;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    typedef enum logic [1:0] {
        HS_OFF = 2'b00,
        HS_HOLD = 2'b01,
        HS_READY = 2'b10,
        HS_ACCEPT = 2'b11
    } gbcd_hs_t;

    typedef enum logic [3:0] {
        CMD_NONE = 4'b0000,
        CMD_GTL = 4'b0001,
        CMD_SDC = 4'b0010,
        CMD_GET = 4'b0011,
        CMD_LLO = 4'b0100,
        CMD_DCL = 4'b0101,
        CMD_SPE = 4'b0110,
        CMD_SPD = 4'b0111,
        CMD_MLA = 4'b1000,
        CMD_MTA = 4'b1001,
        CMD_OTA = 4'b1010,
        CMD_UNL = 4'b1011,
        CMD_UNT = 4'b1100
    } gbcd_cmd_t;

endpackage

// ==== logic/gbcd_decoder.sv ====
`timescale 1ns/1ps

// Function
// - Low level on a uniline means asserted
// - Decode bus bytes as commands only under ATN
// - Bytes without ATN pass on as data only when addressed to listen
// - Controller drives ATN IFC REN; device SRQ
// - REN plus addressing: remote; panel locked if lock_when_remote or lockout
// - EOI marks last byte of a message
// - IFC idles talker and listener state
// - Hold SRQ while service is needed
// - Universal commands act without addressing
// - Local lockout disables the local key
// - Device clear restores default state
// - Poll enable enters serial poll mode
// - Poll disable leaves serial poll mode
// - Addressed commands need prior listen address
// - Selective clear only when addressed
// - Go-to-local leaves remote, may unlock
// - Trigger starts action, unaddressed optional
// - Listen address is primary ORed 20 hex
// - Talk address is primary ORed 40 hex
// - Secondary address bytes are ignored
// - Unlisten makes listener idle
// - Untalk makes talker idle
// - Primary address is five bits
// - All bus lines are low-true
// - Interlocked three-wire byte handshake
module gbcd_decoder #(
    parameter bit GTL_CLEARS_LOCKOUT = 1'b0
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic atn_n,
    input wire logic ifc_n,
    input wire logic ren_n,
    input wire logic eoi_n,
    input wire logic dav_n,
    input wire logic [7:0] dio_n,
    output logic nrfd_out,
    output logic nrfd_oe_n,
    output logic ndac_out,
    output logic ndac_oe_n,
    output logic srq_out,
    output logic srq_oe_n,
    input wire logic [4:0] primary_addr,
    input wire logic service_req,
    input wire logic lock_when_remote,
    input wire logic get_unaddressed,
    input wire logic local_key,
    output logic listener,
    output logic talker,
    output logic remote,
    output logic lockout,
    output logic panel_locked,
    output logic poll_mode,
    output logic dev_clear,
    output logic trigger,
    output logic data_valid,
    input wire logic data_ready,
    output logic [7:0] data,
    output logic data_last
);

    // ========================================================
    // State
    // ========================================================
    typedef struct packed {
        gbcd_pkg::gbcd_hs_t hs;
        logic listener;
        logic talker;
        logic remote;
        logic lockout;
        logic panel_locked;
        logic poll_mode;
        logic dev_clear;
        logic trigger;
        logic nrfd_oe_n;
        logic ndac_oe_n;
        logic srq_oe_n;
        logic drive_level;
        logic head_valid;
        logic [7:0] head_data;
        logic head_last;
        logic tail_valid;
        logic [7:0] tail_data;
        logic tail_last;
    } gbcd_state_t;

    localparam gbcd_state_t RESET_STATE = '{
        hs: gbcd_pkg::HS_OFF,
        listener: gbcd_pkg::RESET_FLAG,
        talker: gbcd_pkg::RESET_FLAG,
        remote: gbcd_pkg::RESET_FLAG,
        lockout: gbcd_pkg::RESET_FLAG,
        panel_locked: gbcd_pkg::RESET_FLAG,
        poll_mode: gbcd_pkg::RESET_FLAG,
        dev_clear: gbcd_pkg::RESET_FLAG,
        trigger: gbcd_pkg::RESET_FLAG,
        nrfd_oe_n: gbcd_pkg::RESET_RELEASED,
        ndac_oe_n: gbcd_pkg::RESET_RELEASED,
        srq_oe_n: gbcd_pkg::RESET_RELEASED,
        drive_level: gbcd_pkg::RESET_FLAG,
        head_valid: gbcd_pkg::RESET_FLAG,
        head_data: gbcd_pkg::RESET_BYTE,
        head_last: gbcd_pkg::RESET_FLAG,
        tail_valid: gbcd_pkg::RESET_FLAG,
        tail_data: gbcd_pkg::RESET_BYTE,
        tail_last: gbcd_pkg::RESET_FLAG
    };

    gbcd_state_t s;
    gbcd_state_t next_s;

    // ========================================================
    // Command decode
    // ========================================================
    function automatic gbcd_pkg::gbcd_cmd_t gbcd_decode(
        input logic [6:0] code,
        input logic [4:0] addr
    );
        logic [6:0] my_listen;
        logic [6:0] my_talk;
        logic [1:0] group;
        gbcd_pkg::gbcd_cmd_t cmd;
        my_listen = {2'b00, addr} | gbcd_pkg::LISTEN_BASE;
        my_talk = {2'b00, addr} | gbcd_pkg::TALK_BASE;
        group = code[gbcd_pkg::GROUP_MSB:gbcd_pkg::GROUP_LSB];
        cmd = gbcd_pkg::CMD_NONE;
        if (code == gbcd_pkg::UNLISTEN) begin
            cmd = gbcd_pkg::CMD_UNL;
        end else if (code == gbcd_pkg::UNTALK) begin
            cmd = gbcd_pkg::CMD_UNT;
        end else if (group == gbcd_pkg::GROUP_LISTEN) begin
            if (code == my_listen) begin
                cmd = gbcd_pkg::CMD_MLA;
            end
        end else if (group == gbcd_pkg::GROUP_TALK) begin
            if (code == my_talk) begin
                cmd = gbcd_pkg::CMD_MTA;
            end else begin
                cmd = gbcd_pkg::CMD_OTA;
            end
        end else if (group == gbcd_pkg::GROUP_SECONDARY) begin
            cmd = gbcd_pkg::CMD_NONE;
        end else begin
            case (code)
                gbcd_pkg::CMD_GO_LOCAL: cmd = gbcd_pkg::CMD_GTL;
                gbcd_pkg::CMD_SEL_CLEAR: cmd = gbcd_pkg::CMD_SDC;
                gbcd_pkg::CMD_TRIGGER: cmd = gbcd_pkg::CMD_GET;
                gbcd_pkg::CMD_LOCKOUT: cmd = gbcd_pkg::CMD_LLO;
                gbcd_pkg::CMD_DEV_CLEAR: cmd = gbcd_pkg::CMD_DCL;
                gbcd_pkg::CMD_POLL_ON: cmd = gbcd_pkg::CMD_SPE;
                gbcd_pkg::CMD_POLL_OFF: cmd = gbcd_pkg::CMD_SPD;
                default: cmd = gbcd_pkg::CMD_NONE;
            endcase
        end
        return cmd;
    endfunction

    // ========================================================
    // Bus view
    // ========================================================
    logic atn;
    logic ifc;
    logic ren;
    logic eoi;
    logic dav;
    logic [7:0] bus_byte;
    logic active;
    logic space;
    logic take;
    logic cmd_take;
    logic data_take;
    logic pop;
    gbcd_pkg::gbcd_cmd_t cmd;

    assign atn = ~atn_n;
    assign ifc = ~ifc_n;
    assign ren = ~ren_n;
    assign eoi = ~eoi_n;
    assign dav = ~dav_n;
    assign bus_byte = ~dio_n;
    // Acceptor takes part under ATN or when addressed to listen
    assign active = atn | s.listener;
    assign space = ~s.tail_valid;
    assign take = (s.hs == gbcd_pkg::HS_READY) & dav & (atn | space);
    assign cmd_take = take & atn;
    assign data_take = take & ~atn & s.listener;
    assign pop = s.head_valid & data_ready;
    assign cmd = cmd_take ? gbcd_decode(bus_byte[6:0], primary_addr)
                          : gbcd_pkg::CMD_NONE;

    // ========================================================
    // Next state
    // ========================================================
    always_comb begin
        next_s = s;
        next_s.dev_clear = 1'b0;
        next_s.trigger = 1'b0;
        unique case (s.hs)
            gbcd_pkg::HS_OFF: begin
                if (active) begin
                    next_s.hs = gbcd_pkg::HS_HOLD;
                end
            end
            gbcd_pkg::HS_HOLD: begin
                if (!active) begin
                    next_s.hs = gbcd_pkg::HS_OFF;
                end else if (!dav && (atn || space)) begin
                    next_s.hs = gbcd_pkg::HS_READY;
                end
            end
            gbcd_pkg::HS_READY: begin
                if (!active) begin
                    next_s.hs = gbcd_pkg::HS_OFF;
                end else if (take) begin
                    next_s.hs = gbcd_pkg::HS_ACCEPT;
                end else if (!atn && !space) begin
                    next_s.hs = gbcd_pkg::HS_HOLD;
                end
            end
            gbcd_pkg::HS_ACCEPT: begin
                if (!dav) begin
                    next_s.hs = active ? gbcd_pkg::HS_HOLD
                                       : gbcd_pkg::HS_OFF;
                end
            end
        endcase
        next_s.nrfd_oe_n = ~(next_s.hs == gbcd_pkg::HS_HOLD ||
                            next_s.hs == gbcd_pkg::HS_ACCEPT);
        next_s.ndac_oe_n = ~(next_s.hs == gbcd_pkg::HS_HOLD ||
                            next_s.hs == gbcd_pkg::HS_READY);

        // Two-entry buffer: head feeds the ports, tail absorbs a stall
        if (pop) begin
            next_s.head_valid = s.tail_valid;
            next_s.head_data = s.tail_data;
            next_s.head_last = s.tail_last;
            next_s.tail_valid = 1'b0;
        end
        if (data_take) begin
            if (!next_s.head_valid) begin
                next_s.head_valid = 1'b1;
                next_s.head_data = bus_byte;
                next_s.head_last = eoi;
            end else begin
                next_s.tail_valid = 1'b1;
                next_s.tail_data = bus_byte;
                next_s.tail_last = eoi;
            end
        end

        unique case (cmd)
            gbcd_pkg::CMD_MLA: begin
                next_s.listener = 1'b1;
                if (ren) begin
                    next_s.remote = 1'b1;
                end
            end
            gbcd_pkg::CMD_MTA: next_s.talker = 1'b1;
            gbcd_pkg::CMD_OTA: next_s.talker = 1'b0;
            gbcd_pkg::CMD_UNL: next_s.listener = 1'b0;
            gbcd_pkg::CMD_UNT: next_s.talker = 1'b0;
            gbcd_pkg::CMD_LLO: begin
                if (ren) begin
                    next_s.lockout = 1'b1;
                end
            end
            gbcd_pkg::CMD_DCL: begin
                next_s.dev_clear = 1'b1;
            end
            gbcd_pkg::CMD_SPE: next_s.poll_mode = 1'b1;
            gbcd_pkg::CMD_SPD: next_s.poll_mode = 1'b0;
            gbcd_pkg::CMD_SDC: begin
                next_s.dev_clear = s.listener;
            end
            gbcd_pkg::CMD_GTL: begin
                if (s.listener) begin
                    next_s.remote = 1'b0;
                    if (GTL_CLEARS_LOCKOUT) begin
                        next_s.lockout = 1'b0;
                    end
                end
            end
            gbcd_pkg::CMD_GET: begin
                next_s.trigger = s.listener | get_unaddressed;
            end
            gbcd_pkg::CMD_NONE: begin
            end
        endcase

        // Clear drops undelivered bytes
        if (next_s.dev_clear) begin
            next_s.head_valid = 1'b0;
            next_s.tail_valid = 1'b0;
        end
        // Front-panel local key works unless locked out
        if (local_key && !s.lockout) begin
            next_s.remote = 1'b0;
        end
        if (!ren) begin
            next_s.remote = 1'b0;
            next_s.lockout = 1'b0;
        end
        if (ifc) begin
            next_s.listener = 1'b0;
            next_s.talker = 1'b0;
            next_s.poll_mode = 1'b0;
        end
        next_s.panel_locked = next_s.remote &
                              (lock_when_remote | next_s.lockout);
        next_s.srq_oe_n = ~service_req;
        next_s.drive_level = 1'b0;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= RESET_STATE;
        end else begin
            s <= next_s;
        end
    end

    // ========================================================
    // Outputs
    // ========================================================
    assign nrfd_out = s.drive_level;
    assign ndac_out = s.drive_level;
    assign srq_out = s.drive_level;
    assign nrfd_oe_n = s.nrfd_oe_n;
    assign ndac_oe_n = s.ndac_oe_n;
    assign srq_oe_n = s.srq_oe_n;
    assign listener = s.listener;
    assign talker = s.talker;
    assign remote = s.remote;
    assign lockout = s.lockout;
    assign panel_locked = s.panel_locked;
    assign poll_mode = s.poll_mode;
    assign dev_clear = s.dev_clear;
    assign trigger = s.trigger;
    assign data_valid = s.head_valid;
    assign data = s.head_data;
    assign data_last = s.head_last;

    // ========================================================
    // Assertions
    // ========================================================
    ifc_idle_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        !ifc_n |=> !listener && !talker)
        else $error("IFC did not idle talker and listener");

    listen_addr_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        cmd_take && ifc_n && bus_byte[6:0] ==
        ({2'b00, primary_addr} | gbcd_pkg::LISTEN_BASE) |=> listener)
        else $error("own listen address not taken");

    talk_addr_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        cmd_take && ifc_n && bus_byte[6:0] ==
        ({2'b00, primary_addr} | gbcd_pkg::TALK_BASE) |=> talker)
        else $error("own talk address not taken");

    unlisten_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        cmd_take && bus_byte[6:0] == gbcd_pkg::UNLISTEN |=> !listener)
        else $error("unlisten left listener set");

    lockout_set_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        cmd_take && !ren_n && bus_byte[6:0] == gbcd_pkg::CMD_LOCKOUT
        |=> lockout)
        else $error("local lockout not set");

    dev_clear_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        cmd_take && bus_byte[6:0] == gbcd_pkg::CMD_DEV_CLEAR
        |=> dev_clear ##1 !dev_clear)
        else $error("device clear not a single pulse");

    sel_clear_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        cmd_take && bus_byte[6:0] == gbcd_pkg::CMD_SEL_CLEAR
        |=> dev_clear == $past(listener))
        else $error("selective clear ignored addressing");

    poll_on_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        cmd_take && ifc_n && bus_byte[6:0] == gbcd_pkg::CMD_POLL_ON
        |=> poll_mode)
        else $error("poll mode not entered");

    poll_off_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        cmd_take && bus_byte[6:0] == gbcd_pkg::CMD_POLL_OFF
        |=> !poll_mode)
        else $error("poll mode not left");

    data_pass_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        data_take && !data_ready |=> data_valid && !dev_clear)
        else $error("data byte not buffered");

    srq_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        service_req [*2] |-> !srq_oe_n)
        else $error("SRQ not held while service needed");

    no_remote_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        ren_n |=> !remote && !lockout)
        else $error("remote held without REN");

endmodule // gbcd_decoder

// ==== verification/gbcd_ctrl_model.sv ====
`timescale 1ns/1ps

// ==========================================================
// Bus controller and talker model
// ==========================================================
module gbcd_ctrl_model (
    input wire logic core_clk,
    input wire logic nrfd_out,
    input wire logic nrfd_oe_n,
    input wire logic ndac_out,
    input wire logic ndac_oe_n,
    output logic atn_n,
    output logic ifc_n,
    output logic ren_n,
    output logic eoi_n,
    output logic dav_n,
    output logic [7:0] dio_n
);
    logic nrfd_w;
    logic ndac_w;

    assign nrfd_w = nrfd_oe_n ? 1'b1 : nrfd_out;
    assign ndac_w = ndac_oe_n ? 1'b1 : ndac_out;

    initial begin
        atn_n = 1'b1;
        ifc_n = 1'b1;
        ren_n = 1'b1;
        eoi_n = 1'b1;
        dav_n = 1'b1;
        dio_n = 8'hFF;
    end

    task automatic set_ren(input logic on);
        @(posedge core_clk);
        ren_n <= ~on;
    endtask

    // IFC driven low for a few cycles
    task automatic pulse_ifc;
        @(posedge core_clk);
        ifc_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        ifc_n <= 1'b1;
    endtask

    task automatic send(input logic atn, input logic [7:0] b,
        input logic eoi, input int dly, input int bound, output logic ok);
        int n;
        @(posedge core_clk);
        atn_n <= ~atn;
        dio_n <= ~b;
        eoi_n <= ~eoi;
        n = 0;
        ok = 1'b0;
        while (n < bound && !ok) begin
            @(posedge core_clk);
            ok = nrfd_w & ~ndac_w;
            n++;
        end
        if (ok) begin
            repeat (dly) @(posedge core_clk);
            dav_n <= 1'b0;
            n = 0;
            ok = 1'b0;
            while (n < bound && !ok) begin
                @(posedge core_clk);
                ok = ndac_w;
                n++;
            end
            // Stale data lines show the inverse once released
            dav_n <= 1'b1;
            eoi_n <= 1'b1;
            dio_n <= b;
        end
    endtask
endmodule // gbcd_ctrl_model

// ==== verification/tb_gpib_bus_command_decoder.sv ====
`timescale 1ns/1ps

module tb_gpib_bus_command_decoder;
    logic core_clk, reset_n, atn_n, ifc_n, ren_n, eoi_n, dav_n;
    logic nrfd_out, nrfd_oe_n, ndac_out, ndac_oe_n, srq_out, srq_oe_n;
    logic service_req, lock_when_remote, get_unaddressed, local_key;
    logic listener, talker, remote, lockout, panel_locked, poll_mode;
    logic dev_clear, trigger, data_valid, data_ready, data_last;
    logic sr_prev, rs_prev, lis, tlk;
    logic [7:0] dio_n, data;
    logic [6:0] c;
    logic [4:0] pa, oa;
    logic [8:0] exp_q[$], got_q[$];
    int error_cnt, compares, n_clr, n_trg, kind;

    gbcd_decoder i_dut (
        .core_clk(core_clk), .reset_n(reset_n), .atn_n(atn_n),
        .ifc_n(ifc_n), .ren_n(ren_n), .eoi_n(eoi_n), .dav_n(dav_n),
        .dio_n(dio_n), .nrfd_out(nrfd_out), .nrfd_oe_n(nrfd_oe_n),
        .ndac_out(ndac_out), .ndac_oe_n(ndac_oe_n), .srq_out(srq_out),
        .srq_oe_n(srq_oe_n), .primary_addr(pa),
        .service_req(service_req), .lock_when_remote(lock_when_remote),
        .get_unaddressed(get_unaddressed), .local_key(local_key),
        .listener(listener), .talker(talker), .remote(remote),
        .lockout(lockout), .panel_locked(panel_locked),
        .poll_mode(poll_mode), .dev_clear(dev_clear), .trigger(trigger),
        .data_valid(data_valid), .data_ready(data_ready), .data(data),
        .data_last(data_last)
    );

    gbcd_ctrl_model i_ctrl (
        .core_clk(core_clk), .nrfd_out(nrfd_out), .nrfd_oe_n(nrfd_oe_n),
        .ndac_out(ndac_out), .ndac_oe_n(ndac_oe_n), .atn_n(atn_n),
        .ifc_n(ifc_n), .ren_n(ren_n), .eoi_n(eoi_n), .dav_n(dav_n),
        .dio_n(dio_n)
    );

    // ==========================================================
    // Clock, monitor and helpers
    // ==========================================================
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if ($urandom_range(7) == 0)
            service_req <= ~service_req;
    end

    always @(negedge core_clk) begin
        if (dev_clear)
            n_clr++;
        if (trigger)
            n_trg++;
        if (data_valid && data_ready)
            got_q.push_back({data_last, data});
        if (reset_n && rs_prev) begin
            check({8'h00, srq_oe_n}, {8'h00, ~sr_prev});
            check({8'h00, srq_out}, 9'h000);
        end
        sr_prev = service_req;
        rs_prev = reset_n;
    end

    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out;
        if (error_cnt == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    function automatic logic [6:0] la(input logic [4:0] a);
        return gbcd_pkg::LISTEN_BASE | {2'h0, a};
    endfunction

    function automatic logic [6:0] ta(input logic [4:0] a);
        return gbcd_pkg::TALK_BASE | {2'h0, a};
    endfunction

    // Status order: listener, talker, remote, lockout, poll
    task automatic chk_st(input logic [4:0] e);
        check({4'h0, listener, talker, remote, lockout, poll_mode},
            {4'h0, e});
    endtask

    task automatic cmd(input logic [6:0] code);
        logic k;
        n_clr = 0;
        n_trg = 0;
        i_ctrl.send(1'b1, {1'($urandom_range(1)), code}, 1'b0,
            $urandom_range(2), 40, k);
        @(negedge core_clk);
        check({8'h00, k}, 9'h001);
    endtask

    task automatic dat(input logic [7:0] b, input logic eoi, input logic e);
        logic k;
        i_ctrl.send(1'b0, b, eoi, $urandom_range(2), 20, k);
        @(negedge core_clk);
        check({8'h00, k}, {8'h00, e});
        if (k)
            exp_q.push_back({eoi, b});
    endtask

    task automatic key;
        @(posedge core_clk);
        local_key <= 1'b1;
        @(posedge core_clk);
        local_key <= 1'b0;
        @(negedge core_clk);
    endtask

    initial begin
        repeat (60000) @(posedge core_clk);
        error_cnt++;
        close_out();
    end

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        reset_n = 1'b0;
        rs_prev = 1'b0;
        service_req = 1'b0;
        data_ready = 1'b0;
        local_key = 1'b0;
        get_unaddressed = 1'b0;
        error_cnt = 0;
        compares = 0;
        n_clr = 0;
        n_trg = 0;
        void'($urandom(58));
        pa = 5'($urandom_range(30));
        oa = (pa == 5'h00) ? 5'h01 : pa - 5'h01;
        lock_when_remote = 1'($urandom_range(1));
        repeat (4) @(posedge core_clk);
        reset_n <= 1'b1;
        @(negedge core_clk);
        chk_st(5'h00);
        check({6'h00, nrfd_oe_n, ndac_oe_n, srq_oe_n}, 9'h007);
        dat(8'($urandom), 1'b0, 1'b0);
        cmd(la(oa));
        chk_st(5'h00);
        cmd(la(pa));
        chk_st(5'h10);
        i_ctrl.set_ren(1'b1);
        cmd(la(pa));
        chk_st(5'h14);
        check({8'h00, panel_locked}, {8'h00, lock_when_remote});
        key();
        chk_st(5'h10);
        cmd(gbcd_pkg::CMD_LOCKOUT);
        cmd(la(pa));
        chk_st(5'h16);
        key();
        chk_st(5'h16);
        check({8'h00, panel_locked}, 9'h001);
        cmd(gbcd_pkg::CMD_GO_LOCAL);
        chk_st(5'h12);
        cmd(ta(pa));
        chk_st(5'h1A);
        cmd(7'h60 | 7'($urandom_range(31)));
        chk_st(5'h1A);
        cmd(gbcd_pkg::CMD_POLL_ON);
        chk_st(5'h1B);
        cmd(gbcd_pkg::CMD_POLL_OFF);
        chk_st(5'h1A);
        cmd(gbcd_pkg::CMD_TRIGGER);
        check(9'(n_trg), 9'h001);
        cmd(gbcd_pkg::CMD_SEL_CLEAR);
        check(9'(n_clr), 9'h001);
        // Buffer fills with the reader stalled, then drains
        cmd(la(pa));
        dat({1'b0, gbcd_pkg::UNLISTEN}, 1'b0, 1'b1);
        dat(8'($urandom), 1'b0, 1'b1);
        dat(8'($urandom), 1'b0, 1'b0);
        check({8'h00, listener}, 9'h001);
        @(posedge core_clk);
        data_ready <= 1'b1;
        dat(8'($urandom), 1'b1, 1'b1);
        repeat (4) @(negedge core_clk);
        check(9'(got_q.size()), 9'(exp_q.size()));
        foreach (exp_q[i])
            check(got_q[i], exp_q[i]);
        cmd(gbcd_pkg::UNLISTEN);
        check({8'h00, listener}, 9'h000);
        cmd(gbcd_pkg::CMD_SEL_CLEAR);
        check(9'(n_clr), 9'h000);
        cmd(gbcd_pkg::CMD_TRIGGER);
        check(9'(n_trg), 9'h000);
        @(posedge core_clk);
        get_unaddressed <= 1'b1;
        cmd(gbcd_pkg::CMD_TRIGGER);
        check(9'(n_trg), 9'h001);
        cmd(gbcd_pkg::CMD_DEV_CLEAR);
        check(9'(n_clr), 9'h001);
        // Random addressing traffic
        cmd(gbcd_pkg::UNTALK);
        lis = 1'b0;
        tlk = 1'b0;
        for (int i = 0; i < 24; i++) begin
            kind = $urandom_range(5);
            case (kind)
                0: c = la(pa);
                1: c = ta(pa);
                2: c = gbcd_pkg::UNLISTEN;
                3: c = gbcd_pkg::UNTALK;
                4: c = ta(oa);
                default: c = la(oa);
            endcase
            cmd(c);
            lis = (kind == 0) ? 1'b1 : (kind == 2) ? 1'b0 : lis;
            tlk = (kind == 1) ? 1'b1 : (kind == 3 || kind == 4) ? 1'b0 : tlk;
            check({7'h00, listener, talker}, {7'h00, lis, tlk});
        end
        cmd(la(pa));
        cmd(ta(pa));
        cmd(gbcd_pkg::CMD_GO_LOCAL);
        check({8'h00, remote}, 9'h000);
        cmd(gbcd_pkg::CMD_POLL_ON);
        i_ctrl.pulse_ifc();
        @(negedge core_clk);
        check({6'h00, listener, talker, poll_mode}, 9'h000);
        cmd(la(pa));
        check({8'h00, remote}, 9'h001);
        i_ctrl.set_ren(1'b0);
        repeat (2) @(negedge core_clk);
        check({7'h00, remote, lockout}, 9'h000);
        close_out();
    end
endmodule // tb_gpib_bus_command_decoder
